// ### verilog/dbc_pkg.sv
// Package: constants for the debug breakpoint control block
`default_nettype none
package dbc_pkg;
  // ---------------------------------------------------------------
  // Register map (debug address space)
  // ---------------------------------------------------------------
  localparam logic [7:0] DBC_ADDR_M1_L       = 8'h04;
  localparam logic [7:0] DBC_ADDR_M1_H       = 8'h05;
  localparam logic [7:0] DBC_ADDR_M1_U       = 8'h06;
  localparam logic [7:0] DBC_ADDR_M2_L       = 8'h08;
  localparam logic [7:0] DBC_ADDR_M2_H       = 8'h09;
  localparam logic [7:0] DBC_ADDR_M2_U       = 8'h0A;
  localparam logic [7:0] DBC_ADDR_M3_L       = 8'h0C;
  localparam logic [7:0] DBC_ADDR_M3_H       = 8'h0D;
  localparam logic [7:0] DBC_ADDR_M3_U       = 8'h0E;
  localparam logic [7:0] DBC_ADDR_BREAK_CTRL = 8'h10;
  localparam logic [7:0] DBC_BREAK_CTRL_RST  = 8'h00;
  // ---------------------------------------------------------------
  // Break control fields
  // ---------------------------------------------------------------
  localparam int DBC_BIT_BREAK_NEXT = 7;
  localparam int DBC_BIT_M3_EN      = 6;
  localparam int DBC_BIT_M2_EN      = 5;
  localparam int DBC_BIT_M1_EN      = 4;
  localparam int DBC_BIT_M1_IGN_LOW = 2;
  // ---------------------------------------------------------------
  // Match sets
  // ---------------------------------------------------------------
  localparam int DBC_NUM_SETS  = 3;
  localparam int DBC_SET_BYTES = 3;
  typedef enum logic [1:0] {DBC_IDLE, DBC_MATCH_PEND, DBC_HALTED} dbc_state_t;
endpackage
`default_nettype wire

// ### verilog/dbc_match_mem.sv
// Match address byte store with registered read ports
`default_nettype none
module dbc_match_mem
  import dbc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Write port
  input  wire logic        wr_en_in,
  input  wire logic [3:0]  wr_idx_in,
  input  wire logic [7:0]  wr_data_in,
  // Registered set outputs
  output logic      [23:0] set1_out,
  output logic      [23:0] set2_out,
  output logic      [23:0] set3_out
);
  logic [7:0] mem [0:15];
  logic [7:0] next_mem [0:15];

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (wr_en_in)
    begin
      next_mem[wr_idx_in] = wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem[i] <= 8'h00;
      end
      set1_out <= 24'h000000;
      set2_out <= 24'h000000;
      set3_out <= 24'h000000;
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem[i] <= next_mem[i];
      end
      set1_out <= {next_mem[6], next_mem[5], next_mem[4]};
      set2_out <= {next_mem[10], next_mem[9], next_mem[8]};
      set3_out <= {next_mem[14], next_mem[13], next_mem[12]};
    end
  end
endmodule // dbc_match_mem
`default_nettype wire

// ### verilog/dbc_break_ctrl.sv
// Breakpoint control: break control byte, address match and break request
//
// How it works
// R1 - Eight-bit write-only break control at address 10h, reset to zero.
// R2 - Bit 7 set halts the CPU at the next instruction; clear, no forced break.
// R3 - Next-instruction break fires only on an instruction's first opcode fetch; the code also fires it at once before the strap is decided.
// R4 - Debug clock and data pins both low at reset set bit 7.
// R5 - Bit 6 enables break when 24-bit address equals match set 3.
// R6 - Bit 5 enables break when 24-bit address equals match set 2.
// R7 - Bit 4 enables break when address equals match set 1.
// R8 - Ignore-low-byte compares only address bits 23 to 8 for set 1.
// R9 - Match breaks apply only at instruction boundaries, after the current one.
// R10 - A match sets bit 7; the host writes it zero to release.
// R11 - Coinciding enabled break sources merge into one break request.
// R12 - Ignore-low-byte option for set 1 lives at bit 2.
// R13 - Compatibility mode address is memory base byte then 16-bit address.
`default_nettype none
module dbc_break_ctrl
  import dbc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Debug register write port
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  // Debug pins sampled for the reset strap
  input  wire logic        debug_clock_pin_in,
  input  wire logic        debug_data_pin_in,
  // CPU fetch status
  input  wire logic        cpu_fetch_in,
  input  wire logic        cpu_first_opcode_in,
  input  wire logic        cpu_instr_end_in,
  input  wire logic [23:0] cpu_addr_in,
  input  wire logic        full_24bit_mode_in,
  input  wire logic [7:0]  memory_base_register_in,
  // Break outputs
  output logic             cpu_break_out,
  output logic [7:0]       break_control_out
);
  // ---------------------------------------------------------------
  // Pin synchronisers and reset strap
  // ---------------------------------------------------------------
  logic [1:0] clk_sync;
  logic [1:0] dat_sync;
  logic [1:0] sync_fill;
  logic       strap_done;
  logic       next_strap_done;
  logic       strap_hit;

  // Synchronisers reset high so an idle pin never reads as a strap
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clk_sync   <= 2'h3;
      dat_sync   <= 2'h3;
      sync_fill  <= 2'h0;
      strap_done <= 1'b0;
    end
    else
    begin
      clk_sync   <= {clk_sync[0], debug_clock_pin_in};
      dat_sync   <= {dat_sync[0], debug_data_pin_in};
      sync_fill  <= {sync_fill[0], 1'b1};
      strap_done <= next_strap_done;
    end
  end

  // Strap decided once both synchronisers hold a sample taken after release
  always_comb
  begin
    next_strap_done = strap_done | sync_fill[1];
    strap_hit       = 1'b0;
    if (!strap_done && sync_fill[1])
    begin
      strap_hit = ~clk_sync[1] & ~dat_sync[1]; // [R4]
    end
  end

  // ---------------------------------------------------------------
  // Match address store
  // ---------------------------------------------------------------
  logic        mem_wr;
  logic [3:0]  mem_idx;
  logic [23:0] set1;
  logic [23:0] set2;
  logic [23:0] set3;

  always_comb
  begin
    mem_wr  = 1'b0;
    mem_idx = 4'h0;
    if (reg_wr_in && (reg_addr_in >= DBC_ADDR_M1_L) && (reg_addr_in <= DBC_ADDR_M3_U)
        && (reg_addr_in[1:0] != 2'h3))
    begin
      mem_wr  = 1'b1;
      mem_idx = reg_addr_in[3:0];
    end
  end

  dbc_match_mem u_mem (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .wr_en_in   (mem_wr),
    .wr_idx_in  (mem_idx),
    .wr_data_in (reg_wdata_in),
    .set1_out   (set1),
    .set2_out   (set2),
    .set3_out   (set3)
  );

  // ---------------------------------------------------------------
  // Address compare
  // ---------------------------------------------------------------
  function automatic logic addr_eq(input logic [23:0] a, input logic [23:0] b,
                                   input logic ign_low);
    addr_eq = (a[23:8] == b[23:8]) && (ign_low || (a[7:0] == b[7:0]));
  endfunction

  logic [7:0]  brk_ctl;
  logic [23:0] cmp_addr;
  logic        any_match;

  always_comb
  begin
    cmp_addr = full_24bit_mode_in ? cpu_addr_in
                                  : {memory_base_register_in, cpu_addr_in[15:0]}; // [R13]
    any_match = cpu_fetch_in && (
        (brk_ctl[DBC_BIT_M3_EN] && addr_eq(cmp_addr, set3, 1'b0))    // [R5]
      | (brk_ctl[DBC_BIT_M2_EN] && addr_eq(cmp_addr, set2, 1'b0))    // [R6]
      | (brk_ctl[DBC_BIT_M1_EN]                                      // [R7]
         && addr_eq(cmp_addr, set1, brk_ctl[DBC_BIT_M1_IGN_LOW]))); // [R8] [R12] [R11]
  end

  // ---------------------------------------------------------------
  // Break state machine and control byte
  // ---------------------------------------------------------------
  dbc_state_t state;
  dbc_state_t next_state;
  logic [7:0] next_brk_ctl;
  logic       next_break;
  logic       at_boundary;

  always_comb
  begin
    next_state   = state;
    next_brk_ctl = brk_ctl;
    at_boundary  = cpu_fetch_in && cpu_first_opcode_in; // [R3]
    if (reg_wr_in && (reg_addr_in == DBC_ADDR_BREAK_CTRL))
    begin
      next_brk_ctl = reg_wdata_in; // [R1]
    end
    if (strap_hit)
    begin
      next_brk_ctl[DBC_BIT_BREAK_NEXT] = 1'b1; // [R4]
    end
    case (state)
      DBC_IDLE:
      begin
        if (any_match && at_boundary)
        begin
          next_brk_ctl[DBC_BIT_BREAK_NEXT] = 1'b1; // [R9] [R10]
        end
        else if (any_match)
        begin
          next_state = DBC_MATCH_PEND; // [R9]
        end
        if (next_brk_ctl[DBC_BIT_BREAK_NEXT])
        begin
          next_state = DBC_HALTED;
        end
      end
      DBC_MATCH_PEND:
      begin
        if (cpu_instr_end_in)
        begin
          next_brk_ctl[DBC_BIT_BREAK_NEXT] = 1'b1; // [R9] [R10]
        end
        if (next_brk_ctl[DBC_BIT_BREAK_NEXT])
        begin
          next_state = DBC_HALTED;
        end
      end
      DBC_HALTED:
      begin
        if (!next_brk_ctl[DBC_BIT_BREAK_NEXT])
        begin
          next_state = DBC_IDLE; // [R10]
        end
      end
      default:
      begin
        next_state = DBC_IDLE;
      end
    endcase
    // Halt asserted at first opcode, or before the strap is decided, while break-on-next is set
    next_break = next_brk_ctl[DBC_BIT_BREAK_NEXT]
                 && (cpu_break_out || at_boundary || !strap_done); // [R2] [R3]
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state             <= DBC_IDLE;
      brk_ctl           <= DBC_BREAK_CTRL_RST; // [R1]
      cpu_break_out     <= 1'b0;
      break_control_out <= DBC_BREAK_CTRL_RST;
    end
    else
    begin
      state             <= next_state;
      brk_ctl           <= next_brk_ctl;
      cpu_break_out     <= next_break;
      break_control_out <= next_brk_ctl;
    end
  end
endmodule // dbc_break_ctrl
`default_nettype wire

// ### bench/dbc_break_ctrl_properties.sv
// Checker for the breakpoint control ports
`default_nettype none
module dbc_chk
  import dbc_pkg::*;
(
  // Inputs
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        cpu_fetch_in,
  input wire logic        cpu_first_opcode_in,
  input wire logic        cpu_instr_end_in,
  // Outputs
  input wire logic        cpu_break_out,
  input wire logic [7:0]  break_control_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire        wc    = reg_wr_in && reg_addr_in == DBC_ADDR_BREAK_CTRL;
  wire        quiet = !cpu_fetch_in && !cpu_instr_end_in;
  wire        bnd   = cpu_fetch_in && cpu_first_opcode_in;
  logic [2:0] age;
  // Edges since reset, past the strap window at 7
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  wire old = age == 3'h7;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_wr;
    wc && quiet && !$past(cpu_fetch_in) && old |=> break_control_out == $past(reg_wdata_in);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_other;
    reg_wr_in && !wc && quiet && !$past(cpu_fetch_in) && old |=> $stable(break_control_out);
  endproperty
  a_other: assert property (p_other) else $error("control changed");
  property p_bit7; $rose(cpu_break_out) |-> break_control_out[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("break without bit 7");
  property p_bnd; $rose(cpu_break_out) && old |-> $past(bnd) || $past(bnd, 2); endproperty
  a_bnd: assert property (p_bnd) else $error("break off boundary");
  property p_src;
    $rose(break_control_out[7]) && old |->
      $past(wc) || $past(bnd) || $past(bnd, 2) || $past(cpu_instr_end_in);
  endproperty
  a_src: assert property (p_src) else $error("bit 7 mid instruction");
  property p_rel;
    wc && !reg_wdata_in[7] && quiet && !$past(cpu_fetch_in) && old ##1 quiet ##1 quiet
      |-> !cpu_break_out;
  endproperty
  a_rel: assert property (p_rel) else $error("break not released");
  property p_hold; cpu_break_out && !$past(wc) && !wc |=> cpu_break_out; endproperty
  a_hold: assert property (p_hold) else $error("break dropped");
  property p_idle;
    !break_control_out[7] && !cpu_break_out && quiet && !reg_wr_in
      && $past(quiet && !reg_wr_in) && old |=> !cpu_break_out;
  endproperty
  a_idle: assert property (p_idle) else $error("forced break");
  c_break: cover property ($rose(cpu_break_out));
  c_rel: cover property ($fell(cpu_break_out));
  c_end: cover property (cpu_instr_end_in && break_control_out[4]);
endmodule // dbc_chk
bind dbc_break_ctrl dbc_chk dbc_chk_i (.sys_clk_in, .rst_in, .reg_wr_in, .reg_addr_in,
  .reg_wdata_in, .cpu_fetch_in, .cpu_first_opcode_in, .cpu_instr_end_in, .cpu_break_out,
  .break_control_out);
`default_nettype wire

// ### bench/dbc_host.sv
// Debug host model: register writes and reset strap pins
`default_nettype none
module dbc_host (
  // Clock
  input  wire logic  sys_clk_in,
  // Register writes
  output logic       reg_wr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  // Strap pins
  output logic       clk_pin_out,
  output logic       data_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    clk_pin_out = 1'b1;
    data_pin_out = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  // Both pins driven to v at the next clock edge
  task automatic pins(input logic v);
    @(posedge sys_clk_in);
    clk_pin_out <= v;
    data_pin_out <= v;
  endtask
endmodule // dbc_host
`default_nettype wire

// ### bench/tb_dbc_break_ctrl.sv
// Testbench for the breakpoint control block
`default_nettype none
module tb_dbc_break_ctrl
  import dbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in, rst_in, reg_wr_in, cpu_fetch_in, cpu_first_opcode_in, cpu_break_out;
  logic        cpu_instr_end_in, full_24bit_mode_in, debug_clock_pin_in, debug_data_pin_in;
  logic [7:0]  reg_addr_in, reg_wdata_in, memory_base_register_in, break_control_out;
  logic [23:0] cpu_addr_in;
  int          n_mismatch, compares;
  dbc_break_ctrl dbc_break_ctrl_i (.sys_clk_in, .rst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .debug_clock_pin_in, .debug_data_pin_in, .cpu_fetch_in, .cpu_first_opcode_in,
    .cpu_instr_end_in, .cpu_addr_in, .full_24bit_mode_in, .memory_base_register_in,
    .cpu_break_out, .break_control_out);
  dbc_host dbc_host_i (.sys_clk_in, .reg_wr_out(reg_wr_in), .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .clk_pin_out(debug_clock_pin_in),
    .data_pin_out(debug_data_pin_in));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic e);
    repeat (2) @(posedge sys_clk_in);
    #1;
    compares++;
    if (cpu_break_out !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t break %b", $time, cpu_break_out);
    end
  endtask
  task automatic chk8(input logic [7:0] e);
    repeat (2) @(posedge sys_clk_in);
    #1;
    compares++;
    if (break_control_out !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t control %h", $time, break_control_out);
    end
  endtask
  task automatic ctl(input logic [7:0] d);
    dbc_host_i.wr(DBC_ADDR_BREAK_CTRL, d);
  endtask
  task automatic setm(input int s, input logic [23:0] a);
    for (int i = 0; i < 3; i++)
      dbc_host_i.wr(8'(4 * s + i), a[8*i +: 8]);
  endtask
  task automatic fetch(input logic [23:0] a, input logic f);
    @(posedge sys_clk_in);
    cpu_fetch_in <= 1'b1;
    cpu_first_opcode_in <= f;
    cpu_addr_in <= a;
    @(posedge sys_clk_in);
    cpu_fetch_in <= 1'b0;
    cpu_addr_in <= ~a;
  endtask
  task automatic t_next;
    dbc_host_i.wr(8'h03, 8'hFF);
    chk8(8'h00);
    ctl(8'h80);
    chk8(8'h80);
    fetch(24'h000100, 1'b0);
    chk(1'b0);
    fetch(24'h000101, 1'b1);
    chk(1'b1);
    ctl(8'h00);
    chk(1'b0);
    fetch(24'h000102, 1'b1);
    chk(1'b0);
    $display("t_next done");
  endtask
  task automatic t_match;
    for (int s = 1; s <= 3; s++)
    begin
      setm(s, 24'hA5C300 + 24'(s));
      for (int e = 0; e < 2; e++)
      begin
        ctl(8'(e << (s + 3)));
        fetch(24'hA5C300 + 24'(s), 1'b1);
        chk(e[0]);
        ctl(8'h00);
      end
    end
    $display("t_match done");
  endtask
  task automatic t_ign;
    setm(1, 24'h123456);
    ctl(8'h14);
    fetch(24'h1234EE, 1'b0);
    chk(1'b0);
    @(posedge sys_clk_in);
    cpu_instr_end_in <= 1'b1;
    @(posedge sys_clk_in);
    cpu_instr_end_in <= 1'b0;
    chk8(8'h94);
    fetch(24'h000000, 1'b1);
    chk(1'b1);
    ctl(8'h10);
    fetch(24'h1234EE, 1'b1);
    chk(1'b0);
    $display("t_ign done");
  endtask
  task automatic t_mode;
    @(posedge sys_clk_in);
    full_24bit_mode_in <= 1'b0;
    memory_base_register_in <= 8'h5A;
    setm(2, 24'h5A1234);
    ctl(8'h20);
    fetch(24'hFF1234, 1'b1);
    chk(1'b1);
    ctl(8'h20);
    @(posedge sys_clk_in);
    full_24bit_mode_in <= 1'b1;
    fetch(24'hFF1234, 1'b1);
    chk(1'b0);
    setm(2, 24'hFF1234);
    setm(3, 24'hFF1234);
    ctl(8'h60);
    fetch(24'hFF1234, 1'b1);
    chk(1'b1);
    chk8(8'hE0);
    ctl(8'h00);
    $display("t_mode done");
  endtask
  task automatic t_strap;
    dbc_host_i.pins(1'b0);
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk8(8'h80);
    chk(1'b1);
    dbc_host_i.pins(1'b1);
    ctl(8'h00);
    chk(1'b0);
    $display("t_strap done");
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog", $time);
    tally_and_finish();
  end
  initial
  begin
    rst_in = 1'b1;
    cpu_fetch_in = 1'b0;
    cpu_first_opcode_in = 1'b0;
    cpu_instr_end_in = 1'b0;
    cpu_addr_in = 24'h000000;
    full_24bit_mode_in = 1'b1;
    memory_base_register_in = 8'h00;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    chk8(DBC_BREAK_CTRL_RST);
    t_next();
    t_match();
    t_ign();
    t_mode();
    t_strap();
    tally_and_finish();
  end
endmodule // tb_dbc_break_ctrl
`default_nettype wire
